// ---- hdl/pam_defs.vh ----
`ifndef PAM_DEFS_VH
`define PAM_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PAM_OFS_CODE 8'h00
`define PAM_OFS_STAT 8'h04
`define PAM_OFS_CTRL 8'h08
`define PAM_OFS_CMD 8'h0c
// Control field positions and reset value
`define PAM_CTRL_ACT 0
`define PAM_CTRL_PIN 1
`define PAM_CTRL_POL 2
`define PAM_CTRL_RST 3'h0
// Command field positions
`define PAM_CMD_CLR 0
`define PAM_CMD_RST 1
`define PAM_CMD_PANIC 2
// Status field positions
`define PAM_ST_ACT 0
`define PAM_ST_CUR 1
`define PAM_ST_STOP 2
`define PAM_ST_CLROK 3
// ----------------------------------------
// Alarm codes
// ----------------------------------------
`define PAM_CODE_NONE 8'h00
`define PAM_CODE_OVV 8'h22
`define PAM_CODE_UVV 8'h23
`define PAM_CODE_POSERR 8'h24
`define PAM_CODE_OVC 8'h20
`define PAM_CODE_PANIC 8'h68
`define PAM_CODE_LSLOG 8'h60
`define PAM_CODE_LSREV 8'h61
`define PAM_CODE_HOMEF 8'h62
`define PAM_CODE_HOMENF 8'h63
`define PAM_CODE_TIMS 8'h64
`define PAM_CODE_HWOT 8'h66
`define PAM_CODE_SWOT 8'h67
`define PAM_CODE_OFSLS 8'h6a
`define PAM_CODE_MPAR 8'h70
`define PAM_CODE_SENMV 8'h28
`define PAM_CODE_SEN 8'h42
`define PAM_CODE_START 8'h43
`define PAM_CODE_NVM 8'h41
`define PAM_CODE_SYS 8'hf0
`define PAM_CODE_MEM 8'hf1
`define PAM_CODE_SEQ 8'hf2
// Blink groups; steady lit is its own value
`define PAM_BLK_OFF 4'h0
`define PAM_BLK_3 4'h3
`define PAM_BLK_5 4'h5
`define PAM_BLK_6 4'h6
`define PAM_BLK_7 4'h7
`define PAM_BLK_8 4'h8
`define PAM_BLK_9 4'h9
`define PAM_BLK_ON 4'hf
// System action classes
`define PAM_ACT_CUR 2'h0
`define PAM_ACT_STOP 2'h1
`define PAM_ACT_CFG 2'h2
// Clear classes
`define PAM_CLS_NONE 2'h0
`define PAM_CLS_COND 2'h1
`define PAM_CLS_ALWAYS 2'h2
// ----------------------------------------
// Fault indices, lowest index wins
// ----------------------------------------
`define PAM_NFAULT 21
`define PAM_F_SYS 5'h00
`define PAM_F_MEM 5'h01
`define PAM_F_SEQ 5'h02
`define PAM_F_NVM 5'h03
`define PAM_F_SENMV 5'h04
`define PAM_F_SEN 5'h05
`define PAM_F_START 5'h06
`define PAM_F_OVC 5'h07
`define PAM_F_OVV 5'h08
`define PAM_F_UVV 5'h09
`define PAM_F_POSERR 5'h0a
`define PAM_F_PANIC 5'h0b
`define PAM_F_LSLOG 5'h0c
`define PAM_F_LSREV 5'h0d
`define PAM_F_HOMEF 5'h0e
`define PAM_F_HOMENF 5'h0f
`define PAM_F_TIMS 5'h10
`define PAM_F_OFSLS 5'h11
`define PAM_F_HWOT 5'h12
`define PAM_F_SWOT 5'h13
`define PAM_F_MPAR 5'h14
// ----------------------------------------
// Timing
// ----------------------------------------
`define PAM_CLK_MHZ 200
`define PAM_BLINK_MS 200
`define PAM_GAP_MS 1000
`endif

// ---- hdl/pam_fault_pick.v ----
`timescale 1ns/1ps
`include "pam_defs.vh"
module pam_fault_pick (
    // Pending fault levels
    input wire [`PAM_NFAULT-1:0] fault_vec,
    // Chosen fault and its table entry
    output reg pick_valid,
    output reg [4:0] pick_idx,
    output wire [7:0] pick_code,
    output wire [3:0] pick_blink,
    output wire [1:0] pick_act,
    output wire [1:0] pick_cls
);
    integer i;
    wire [15:0] entry;

    // Table entry: code, blink group, action class, clear class
    function [15:0] fault_entry;
        input [4:0] idx;
        begin
            case (idx)
                `PAM_F_SYS: fault_entry = {`PAM_CODE_SYS, `PAM_BLK_ON, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_MEM: fault_entry = {`PAM_CODE_MEM, `PAM_BLK_ON, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_SEQ: fault_entry = {`PAM_CODE_SEQ, `PAM_BLK_ON, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_NVM: fault_entry = {`PAM_CODE_NVM, `PAM_BLK_9, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_SENMV: fault_entry = {`PAM_CODE_SENMV, `PAM_BLK_8, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_SEN: fault_entry = {`PAM_CODE_SEN, `PAM_BLK_8, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_START: fault_entry = {`PAM_CODE_START, `PAM_BLK_8, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_OVC: fault_entry = {`PAM_CODE_OVC, `PAM_BLK_5, `PAM_ACT_CUR, `PAM_CLS_NONE};
                `PAM_F_OVV: fault_entry = {`PAM_CODE_OVV, `PAM_BLK_3, `PAM_ACT_CUR, `PAM_CLS_COND};
                `PAM_F_UVV: fault_entry = {`PAM_CODE_UVV, `PAM_BLK_3, `PAM_ACT_CUR, `PAM_CLS_COND};
                `PAM_F_POSERR: fault_entry = {`PAM_CODE_POSERR, `PAM_BLK_3, `PAM_ACT_CUR, `PAM_CLS_COND};
                `PAM_F_PANIC: fault_entry = {`PAM_CODE_PANIC, `PAM_BLK_6, `PAM_ACT_CFG, `PAM_CLS_ALWAYS};
                `PAM_F_LSLOG: fault_entry = {`PAM_CODE_LSLOG, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_LSREV: fault_entry = {`PAM_CODE_LSREV, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_HOMEF: fault_entry = {`PAM_CODE_HOMEF, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_HOMENF: fault_entry = {`PAM_CODE_HOMENF, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_TIMS: fault_entry = {`PAM_CODE_TIMS, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_OFSLS: fault_entry = {`PAM_CODE_OFSLS, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                `PAM_F_HWOT: fault_entry = {`PAM_CODE_HWOT, `PAM_BLK_7, `PAM_ACT_CFG, `PAM_CLS_ALWAYS};
                `PAM_F_SWOT: fault_entry = {`PAM_CODE_SWOT, `PAM_BLK_7, `PAM_ACT_CFG, `PAM_CLS_ALWAYS};
                `PAM_F_MPAR: fault_entry = {`PAM_CODE_MPAR, `PAM_BLK_7, `PAM_ACT_STOP, `PAM_CLS_ALWAYS};
                default: fault_entry = {`PAM_CODE_NONE, `PAM_BLK_OFF, `PAM_ACT_STOP, `PAM_CLS_NONE};
            endcase
        end
    endfunction

    // Priority scan from the top down so the lowest index is kept
    always @* begin
        pick_valid = 1'b0;
        pick_idx = 5'h00;
        for (i = `PAM_NFAULT - 1; i >= 0; i = i - 1) begin
            if (fault_vec[i]) begin
                pick_valid = 1'b1;
                pick_idx = i[4:0];
            end
        end
    end

    assign entry = fault_entry(pick_idx);
    assign pick_code = entry[15:8];
    assign pick_blink = entry[7:4];
    assign pick_act = entry[3:2];
    assign pick_cls = entry[1:0];
endmodule // pam_fault_pick

// ---- hdl/pam_blink.v ----
`timescale 1ns/1ps
`include "pam_defs.vh"
module pam_blink #(
    parameter [31:0] TICK_CYC = 32'd40000000
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Blink group, off, or steady
    input wire [3:0] blink_cnt,
    // Indicator drive
    output reg led_r
);
    // Gap between bursts in blink half periods
    localparam [31:0] GAP_FULL = `PAM_GAP_MS / `PAM_BLINK_MS;
    localparam [4:0] GAP_TICKS = GAP_FULL[4:0];
    reg [31:0] pre_r;
    reg [3:0] cnt_r;
    reg [4:0] ph_r;
    wire tick;
    wire [4:0] last_ph;
    wire [4:0] ph_nxt;
    wire [4:0] burst_len;

    assign tick = (pre_r == TICK_CYC - 32'd1);
    assign burst_len = {cnt_r, 1'b0};
    assign last_ph = burst_len + GAP_TICKS - 5'h01;
    assign ph_nxt = (ph_r == last_ph) ? 5'h00 : ph_r + 5'h01;

    // Prescaler, phase walk and indicator level
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= 32'h0;
            cnt_r <= `PAM_BLK_OFF;
            ph_r <= 5'h00;
            led_r <= 1'b0;
        end else if (blink_cnt != cnt_r) begin
            // New group restarts the burst at once, so counting starts clean
            cnt_r <= blink_cnt;
            pre_r <= 32'h0;
            ph_r <= 5'h00;
            led_r <= (blink_cnt != `PAM_BLK_OFF);
        end else if (cnt_r == `PAM_BLK_OFF || cnt_r == `PAM_BLK_ON) begin
            // Dark or steady: no pattern to walk
            pre_r <= 32'h0;
            led_r <= (cnt_r == `PAM_BLK_ON);
        end else if (tick) begin
            // Even phases inside the burst are lit, then a long dark gap
            pre_r <= 32'h0;
            ph_r <= ph_nxt;
            led_r <= (ph_nxt < burst_len) && !ph_nxt[0];
        end else begin
            pre_r <= pre_r + 32'h1;
        end
    end
endmodule // pam_blink

// ---- hdl/pam_alarm_mgr.v ----
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "pam_defs.vh"
module pam_alarm_mgr #(
    // Blink half period in clock cycles
    parameter [31:0] BLINK_CYC = `PAM_BLINK_MS * `PAM_CLK_MHZ * 1000
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,

    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,

    // Supply and drive detectors
    input wire flt_over_volt,
    input wire flt_under_volt,
    input wire flt_pos_err,
    input wire flt_over_curr,

    // Stop and travel limit signals
    input wire panic_stop_input,
    input wire lim_pos,
    input wire lim_neg,
    input wire soft_limit_out,

    // Homing sequence status
    input wire homing_active,
    input wire homing_dir_pos,
    input wire home_unstable,
    input wire origin_switch_not_found,
    input wire timing_position_missing,
    input wire offset_move_active,

    // Motion and feedback faults
    input wire motion_param_err,
    input wire sens_err_moving,
    input wire sens_fault,
    input wire startup_motion,

    // Internal integrity faults
    input wire nvm_corrupt,
    input wire sys_state_err,
    input wire mem_access_err,
    input wire seq_code_err,

    // Alarm outputs
    output reg motor_current_off,
    output reg motion_stop,
    output reg alarm_out,
    output wire alarm_led,
    output reg [7:0] alarm_code
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg active_r;             // An alarm is latched
    reg [4:0] idx_r;          // Index of the latched fault
    reg [3:0] blink_r;        // Blink group of the latched fault
    reg [1:0] act_r;          // Action class of the latched fault
    reg [1:0] cls_r;          // Clear class of the latched fault
    reg [2:0] ctrl_r;         // Action setting, pin assign, polarity
    wire [`PAM_NFAULT-1:0] fault_vec;

    // Highest ranked pending fault
    wire pend_valid;
    wire [4:0] pend_idx;
    wire [7:0] pend_code;
    wire [3:0] pend_blink;
    wire [1:0] pend_act;
    wire [1:0] pend_cls;

    // Command strobes
    wire cmd_hit;
    wire cmd_clear;
    wire cmd_reset;
    wire cmd_panic;

    // Limit helpers
    wire lim_any;
    wire lim_both;

    // Clear terms
    wire cond_gone;
    wire clear_ok;
    wire leave;

    // Next output values
    wire cur_nxt;
    wire stop_nxt;
    wire alarm_nxt;
    wire [3:0] blink_nxt;

    // Read mux
    reg [31:0] rdata_nxt;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Commands are one-shot strobes taken from a write to the command word
    // Several bits in one write act together
    assign cmd_hit = reg_wr && (reg_addr == `PAM_OFS_CMD);
    assign cmd_clear = cmd_hit && reg_wdata[`PAM_CMD_CLR];
    assign cmd_reset = cmd_hit && reg_wdata[`PAM_CMD_RST];
    assign cmd_panic = cmd_hit && reg_wdata[`PAM_CMD_PANIC];

    // ----------------------------------------
    // Fault conditions
    // ----------------------------------------
    assign lim_any = lim_pos || lim_neg;
    assign lim_both = lim_pos && lim_neg;

    // Internal integrity faults
    assign fault_vec[`PAM_F_SYS] = sys_state_err;
    assign fault_vec[`PAM_F_MEM] = mem_access_err;
    assign fault_vec[`PAM_F_SEQ] = seq_code_err;
    assign fault_vec[`PAM_F_NVM] = nvm_corrupt;

    // Feedback and start-up faults
    assign fault_vec[`PAM_F_SENMV] = sens_err_moving;
    assign fault_vec[`PAM_F_SEN] = sens_fault;
    assign fault_vec[`PAM_F_START] = startup_motion;

    // Power stage faults
    assign fault_vec[`PAM_F_OVC] = flt_over_curr;
    assign fault_vec[`PAM_F_OVV] = flt_over_volt;
    assign fault_vec[`PAM_F_UVV] = flt_under_volt;
    assign fault_vec[`PAM_F_POSERR] = flt_pos_err;

    // Panic stop from the pin or from the command word
    assign fault_vec[`PAM_F_PANIC] = panic_stop_input || cmd_panic;

    // Limit logic: both at once outranks every other limit case
    assign fault_vec[`PAM_F_LSLOG] = lim_both;

    // Limit on the side away from the homing direction
    assign fault_vec[`PAM_F_LSREV] = homing_active &&
        (homing_dir_pos ? lim_neg : lim_pos);
    // Homing steps count only while homing runs
    assign fault_vec[`PAM_F_HOMEF] = homing_active && home_unstable;
    assign fault_vec[`PAM_F_HOMENF] = homing_active &&
        origin_switch_not_found;
    assign fault_vec[`PAM_F_TIMS] = homing_active &&
        timing_position_missing;
    // Any limit during the offset move
    assign fault_vec[`PAM_F_OFSLS] = offset_move_active && lim_any;

    // Plain overtravel only when no homing step owns the limit
    assign fault_vec[`PAM_F_HWOT] = !homing_active && !offset_move_active &&
        lim_any;
    // Software limit and parameter faults
    assign fault_vec[`PAM_F_SWOT] = soft_limit_out;
    assign fault_vec[`PAM_F_MPAR] = motion_param_err;

    // ----------------------------------------
    // Priority pick and alarm table
    // ----------------------------------------
    // Lowest index wins when faults rise together
    pam_fault_pick u_pick (
        .fault_vec(fault_vec),
        .pick_valid(pend_valid),
        .pick_idx(pend_idx),
        .pick_code(pend_code),
        .pick_blink(pend_blink),
        .pick_act(pend_act),
        .pick_cls(pend_cls)
    );

    // ----------------------------------------
    // Clear qualification
    // ----------------------------------------
    // The latched fault's own source must be quiet for a conditional clear
    assign cond_gone = !fault_vec[idx_r];

    // Unclearable classes simply never qualify
    assign clear_ok = active_r && ((cls_r == `PAM_CLS_ALWAYS) ||
        ((cls_r == `PAM_CLS_COND) && cond_gone));

    // System reset ends any alarm, clear only a qualified one
    assign leave = cmd_reset || (cmd_clear && clear_ok);

    // ----------------------------------------
    // Alarm latch
    // ----------------------------------------
    // The first alarm is held; later faults do not overwrite it.
    // A fault pending in the very cycle of a clear is latched at once,
    // so an event never slips through the clear.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Nothing held after power-up
            active_r <= 1'b0;
            idx_r <= 5'h00;
            alarm_code <= `PAM_CODE_NONE;
            blink_r <= `PAM_BLK_OFF;
            act_r <= `PAM_ACT_STOP;
            cls_r <= `PAM_CLS_NONE;
        end else if (!active_r || leave) begin
            // Idle, or leaving at this edge: free to take a fault
            if (pend_valid) begin
                // Take the highest ranked pending fault
                active_r <= 1'b1;
                idx_r <= pend_idx;
                alarm_code <= pend_code;
                blink_r <= pend_blink;
                act_r <= pend_act;
                cls_r <= pend_cls;
            end else begin
                // Idle: code zero, indicator dark
                active_r <= 1'b0;
                idx_r <= 5'h00;
                alarm_code <= `PAM_CODE_NONE;
                blink_r <= `PAM_BLK_OFF;
                act_r <= `PAM_ACT_STOP;
                cls_r <= `PAM_CLS_NONE;
            end
        end
    end

    // ----------------------------------------
    // System action
    // ----------------------------------------
    // Current off also stops motion, since nothing can move without torque
    assign cur_nxt = active_r && ((act_r == `PAM_ACT_CUR) ||
        ((act_r == `PAM_ACT_CFG) && ctrl_r[`PAM_CTRL_ACT]));
    // Every alarm stops motion and sequence processing
    assign stop_nxt = active_r;

    // Alarm pin stays low unless the function is assigned, whatever the polarity bit
    assign alarm_nxt = ctrl_r[`PAM_CTRL_PIN] &&
        (active_r ^ ctrl_r[`PAM_CTRL_POL]);

    // Action outputs follow the latch one cycle later
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Outputs idle while reset is held
            motor_current_off <= 1'b0;
            motion_stop <= 1'b0;
            alarm_out <= 1'b0;
        end else begin
            motor_current_off <= cur_nxt;
            motion_stop <= stop_nxt;
            alarm_out <= alarm_nxt;
        end
    end

    // ----------------------------------------
    // Indicator
    // ----------------------------------------
    // Group as it stands after this edge, so lamp and code change together
    assign blink_nxt = (!active_r || leave) ?
        (pend_valid ? pend_blink : `PAM_BLK_OFF) : blink_r;

    // Group number drives the burst length; steady and dark are coded apart
    pam_blink #(
        .TICK_CYC(BLINK_CYC)
    ) u_blink (
        .mclk(mclk),
        .arst_n(arst_n),
        .blink_cnt(blink_nxt),
        .led_r(alarm_led)
    );

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // Action setting is read live, so a change applies to a held alarm
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= `PAM_CTRL_RST;
        end else if (reg_wr && (reg_addr == `PAM_OFS_CTRL)) begin
            // Only the three defined bits are kept
            ctrl_r <= reg_wdata[2:0];
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped offsets and the write-only command word read as zero
    always @* begin
        rdata_nxt = 32'h0;
        case (reg_addr)
            `PAM_OFS_CODE: begin
                rdata_nxt[7:0] = alarm_code;
            end

            `PAM_OFS_STAT: begin
                rdata_nxt[`PAM_ST_ACT] = active_r;
                rdata_nxt[`PAM_ST_CUR] = motor_current_off;
                rdata_nxt[`PAM_ST_STOP] = motion_stop;
                rdata_nxt[`PAM_ST_CLROK] = clear_ok;
            end

            `PAM_OFS_CTRL: begin
                rdata_nxt[2:0] = ctrl_r;
            end

            default: begin
                rdata_nxt = 32'h0;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            // Sample the mux in the strobe cycle
            reg_rdata <= rdata_nxt;
        end else begin
            // Idle bus reads as zero
            reg_rdata <= 32'h0;
        end
    end
endmodule // pam_alarm_mgr

// ---- testbench/pam_alarm_chk_asserts.sv ----
`timescale 1ns/1ps
// ------------------------------------
// Port checker for the alarm manager
// ------------------------------------
module pam_alarm_chk (
    // Clock and reset
    input logic mclk,
    input logic arst_n,
    // Register port
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    // Watched faults and outputs
    input logic flt_over_volt,
    input logic sys_state_err,
    input logic motor_current_off,
    input logic motion_stop,
    input logic alarm_led,
    input logic [7:0] alarm_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // System reset command is the only way out of unclearable alarms
    wire rst_cmd = reg_wr && reg_addr == 8'h0c && reg_wdata[1];
    rd_slot_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    sys_first_a: assert property (alarm_code == 8'h00 && sys_state_err |=> alarm_code == 8'hf0)
        else $error("internal fault not latched");
    code_hold_a: assert property (alarm_code != 8'h00 && !reg_wr |=> $stable(alarm_code))
        else $error("held code changed");
    ovc_noclear_a: assert property (alarm_code == 8'h20 && !rst_cmd |=> alarm_code == 8'h20)
        else $error("over-current alarm left");
    ovv_cond_a: assert property (alarm_code == 8'h22 && flt_over_volt && !rst_cmd |=> alarm_code == 8'h22)
        else $error("over-voltage cleared while present");
    cur_follow_a: assert property (alarm_code inside {8'h20, 8'h28, 8'h41} |=> motor_current_off)
        else $error("current not disabled");
    stop_follow_a: assert property (1'b1 |=> motion_stop == ($past(alarm_code) != 8'h00))
        else $error("stop does not track alarm");
    led_dark_a: assert property (alarm_code == 8'h00 |-> !alarm_led)
        else $error("indicator lit while idle");
    led_steady_a: assert property (alarm_code[7:4] == 4'hf |-> alarm_led)
        else $error("indicator not steady");
    cover property (alarm_code == 8'h60);
    cover property (alarm_code == 8'h22 && flt_over_volt && reg_wr);
    cover property ($fell(alarm_code != 8'h00));
endmodule // pam_alarm_chk
bind pam_alarm_mgr pam_alarm_chk u_pam_alarm_chk (.mclk(mclk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flt_over_volt(flt_over_volt), .sys_state_err(sys_state_err),
    .motor_current_off(motor_current_off), .motion_stop(motion_stop),
    .alarm_led(alarm_led), .alarm_code(alarm_code));

// ---- testbench/pam_fault_src.sv ----
`timescale 1ns/1ps
// ------------------------------------
// Fault detectors and motion context
// ------------------------------------
module pam_fault_src (
    // Clock
    input logic mclk,
    // Case select and enable
    input logic [4:0] sel,
    input logic go,
    // Fault and context levels
    output logic [21:0] pins = 22'h0
);
    // Context bits: 8 homing, 9 toward positive, 13 offset move
    always @(posedge mclk) begin
        if (!go) begin
            pins <= 22'h0; // Cause removed before the clear
        end else begin
            case (sel)
                5'd5: pins <= 22'h000060; // Both limits
                5'd6: pins <= 22'h000340; // Negative limit homing positive
                5'd7: pins <= 22'h000500;
                5'd8: pins <= 22'h000900;
                5'd9: pins <= 22'h001100;
                5'd10: pins <= 22'h000020;
                5'd11: pins <= 22'h000080;
                5'd12: pins <= 22'h002020;
                5'd21: pins <= 22'h3fffff; // Everything at once
                default: pins <= (sel < 5'd5) ? 22'h1 << sel : 22'h1 << (sel + 5'd1);
            endcase
        end
    end
endmodule // pam_fault_src

// ---- testbench/pam_alarm_mgr_test.sv ----
`timescale 1ns/1ps
module pam_alarm_mgr_test;
    // ------------------------------------
    // Stimulus, responses, bookkeeping
    // ------------------------------------
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [4:0] f_sel = 5'h00;
    logic f_go = 1'b0;
    logic [31:0] seed = 32'hefaa8048;
    logic [31:0] d, ctl;
    logic [7:0] ex;
    logic cur, prev;
    wire [21:0] f;
    wire [31:0] reg_rdata;
    wire cur_off, stop, a_out, led;
    wire [7:0] code;
    integer err_count = 0, num_checks = 0, cyc = 0, k, n, j, p, rise;
    // Expected code per partner case; last case is all faults
    logic [7:0] codes [$] = '{8'h22, 8'h23, 8'h24, 8'h20, 8'h68, 8'h60, 8'h61, 8'h62, 8'h63,
        8'h64, 8'h66, 8'h67, 8'h6a, 8'h70, 8'h28, 8'h42, 8'h43, 8'h41, 8'hf0, 8'hf1, 8'hf2, 8'hf0};
    always #2.5 mclk = ~mclk;
    pam_alarm_mgr #(.BLINK_CYC(32'd4)) u_pam_alarm_mgr (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flt_over_volt(f[0]), .flt_under_volt(f[1]), .flt_pos_err(f[2]),
        .flt_over_curr(f[3]), .panic_stop_input(f[4]), .lim_pos(f[5]), .lim_neg(f[6]),
        .soft_limit_out(f[7]), .homing_active(f[8]), .homing_dir_pos(f[9]),
        .home_unstable(f[10]), .origin_switch_not_found(f[11]),
        .timing_position_missing(f[12]), .offset_move_active(f[13]),
        .motion_param_err(f[14]), .sens_err_moving(f[15]), .sens_fault(f[16]),
        .startup_motion(f[17]), .nvm_corrupt(f[18]), .sys_state_err(f[19]),
        .mem_access_err(f[20]), .seq_code_err(f[21]), .motor_current_off(cur_off),
        .motion_stop(stop), .alarm_out(a_out), .alarm_led(led), .alarm_code(code));
    pam_fault_src u_pam_fault_src (.mclk(mclk), .sel(f_sel), .go(f_go), .pins(f));
    // Blink group of a code; zero stands for steady lit
    function automatic integer grp(input logic [7:0] c);
        case (c)
            8'h22, 8'h23, 8'h24: grp = 3;
            8'h20: grp = 5;
            8'h68: grp = 6;
            8'h28, 8'h42, 8'h43: grp = 8;
            8'h41: grp = 9;
            8'hf0, 8'hf1, 8'hf2: grp = 0;
            default: grp = 7;
        endcase
    endfunction
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // Strobes are one cycle and change just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard, well above the whole sequence
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'h08, d); chk(d, 32'h0);
        rd(8'h00, d); chk(d, 32'h0);
        rd(8'h10, d); chk(d, 32'h0);
        for (k = 0; k < 22; k++) begin
            ex = codes[k];
            n = grp(ex);
            d = xs();
            ctl = {29'h0, d[2:0]};
            wr(8'h08, d);
            rd(8'h08, d); chk(d, ctl);
            f_sel <= k[4:0];
            f_go <= 1'b1;
            for (j = 0; j < 9 && code !== ex; j++) @(posedge mclk) #1;
            chk(code, ex); chk(led, 1'b1);
            p = (2 * n + 5) * 4;
            prev = 1'b1;
            rise = 0;
            // Two full bursts from the latch give 2n-1 fresh rises
            for (j = 1; j < 2 * p; j++) begin
                @(posedge mclk) #1;
                rise = rise + (led && !prev);
                prev = led;
            end
            chk(rise, n ? 2 * n - 1 : 0);
            if (n == 0) chk(led, 1'b1);
            cur = n inside {0, 3, 5, 8, 9} || (ex inside {8'h66, 8'h67, 8'h68} && ctl[0]);
            rd(8'h04, d);
            chk(d, {28'h0, (n == 6 || n == 7), 1'b1, cur, 1'b1});
            chk(cur_off, cur); chk(stop, 1'b1);
            chk(a_out, ctl[1] & ~ctl[2]);
            d = xs();
            wr(8'h0c, {d[31:3], 3'b001});
            rd(8'h00, d); chk(d, ex);
            f_go <= 1'b0;
            wr(8'h0c, 32'h1);
            rd(8'h00, d); chk(d, n inside {0, 5, 8, 9} ? ex : 8'h00);
            wr(8'h0c, 32'h2);
            rd(8'h00, d); chk(d, 32'h0);
            chk(stop, 1'b0); chk(led, 1'b0); chk(a_out, ctl[1] & ctl[2]);
            $display("case %0d code %h done", k, ex);
        end
        wr(8'h0c, 32'h4);
        rd(8'h00, d); chk(d, 32'h68);
        $display("panic command done");
        wrap_up();
    end
endmodule // pam_alarm_mgr_test
